// ==== inc/mb_func_pkg.sv ====
// Constants shared by the request interpreter and its counters.
package mb_func_pkg;

  localparam logic [7:0] FC_RD_COILS  = 8'h01;
  localparam logic [7:0] FC_RD_INPUTS = 8'h02;
  localparam logic [7:0] FC_RD_HOLD   = 8'h03;
  localparam logic [7:0] FC_RD_INREG  = 8'h04;
  localparam logic [7:0] FC_WR_COIL   = 8'h05;
  localparam logic [7:0] FC_WR_REG    = 8'h06;
  localparam logic [7:0] FC_DIAG      = 8'h08;
  localparam logic [7:0] FC_WR_COILS  = 8'h0f;
  localparam logic [7:0] FC_WR_REGS   = 8'h10;
  localparam logic [7:0] FC_RW_REGS   = 8'h17;

  localparam logic [15:0] SUB_ECHO     = 16'h0000;
  localparam logic [15:0] SUB_RESTART  = 16'h0001;
  localparam logic [15:0] SUB_LISTEN   = 16'h0004;
  localparam logic [15:0] SUB_CLEAR    = 16'h000a;
  localparam logic [15:0] SUB_BUS_MSG  = 16'h000b;
  localparam logic [15:0] SUB_BUS_ERR  = 16'h000c;
  localparam logic [15:0] SUB_EXC_CNT  = 16'h000d;
  localparam logic [15:0] SUB_SLV_MSG  = 16'h000e;
  localparam logic [15:0] SUB_NO_RSP   = 16'h000f;
  localparam logic [15:0] SUB_NACK_CNT = 16'h0010;
  localparam logic [15:0] SUB_OVR_CNT  = 16'h0012;

  localparam logic [7:0] EXC_NONE      = 8'h00;
  localparam logic [7:0] EXC_FUNCTION  = 8'h01;
  localparam logic [7:0] EXC_ADDRESS   = 8'h02;
  localparam logic [7:0] EXC_VALUE     = 8'h03;
  localparam logic [7:0] EXC_FAILURE   = 8'h04;

  localparam int CNT_W     = 16;
  localparam int NUM_CNT   = 7;
  localparam int CNT_BUS   = 0;
  localparam int CNT_CRC   = 1;
  localparam int CNT_EXC   = 2;
  localparam int CNT_SLV   = 3;
  localparam int CNT_NORSP = 4;
  localparam int CNT_NACK  = 5;
  localparam int CNT_OVR   = 6;

  localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
  localparam logic [15:0]      DIAG_RST = 16'h0000;
  localparam int DIAG_CRC_BIT = 0;
  localparam int DIAG_OVR_BIT = 1;
  localparam int DIAG_EXC_BIT = 2;

endpackage

// ==== inc/diag_cnt_if.sv ====
// Increment, clear and readout lines between interpreter and counters.
`timescale 1ns/100ps
`default_nettype none
interface diag_cnt_if
  import mb_func_pkg::*;
();
  logic                 clear;
  logic [NUM_CNT-1:0]   inc;
  logic [CNT_W-1:0]     count [NUM_CNT];

  modport ctrl (output clear, output inc, input count);
  modport cnt  (input clear, input inc, output count);
endinterface
`default_nettype wire

// ==== verilog/diag_counter.sv ====
// One wrapping diagnostic event counter.
`timescale 1ns/100ps
`default_nettype none
module diag_counter
  import mb_func_pkg::*;
#(
  parameter int IDX = 0
) (
  input  wire logic clock,
  input  wire logic rstn,
  diag_cnt_if.cnt   cif
);
  logic [CNT_W-1:0] cnt_q;

  // An event in the clearing cycle is kept, so the count restarts at one.
  always_ff @(posedge clock)
  begin
    if (!rstn)
      cnt_q <= CNT_RST;
    else if (cif.inc[IDX])
      cnt_q <= cif.clear ? CNT_RST + 16'h0001 : cnt_q + 16'h0001;
    else if (cif.clear)
      cnt_q <= CNT_RST;
  end

  assign cif.count[IDX] = cnt_q;
endmodule
`default_nettype wire

// ==== verilog/mb_func_handler.sv ====
// Request interpreter: function decode, diagnostics, exceptions, presets.
`timescale 1ns/100ps
`default_nettype none
module mb_func_handler
  import mb_func_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              frame_seen,
  input  wire logic              frame_crc_err,
  input  wire logic              frame_overrun,
  input  wire logic              nack_sent,
  input  wire logic              parity_en,
  output logic                   two_stop_bits,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [7:0]        req_func,
  input  wire logic              req_bcast,
  input  wire logic [15:0]       req_sub,
  input  wire logic [15:0]       req_data,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [15:0]       req_words,
  input  wire logic              req_addr_ok,
  input  wire logic              req_count_ok,
  input  wire logic              req_value_ok,
  input  wire logic              app_fail,
  input  wire logic              word_valid,
  output logic                   word_ready,
  input  wire logic [15:0]       word_data,
  output logic                   reg_wr_req,
  output logic [ADDR_W-1:0]      reg_wr_addr,
  output logic [15:0]            reg_wr_data,
  input  wire logic              reg_wr_bad,
  output logic                   rsp_valid,
  input  wire logic              rsp_ready,
  output logic [7:0]             rsp_func,
  output logic                   rsp_exc,
  output logic [7:0]             rsp_code,
  output logic [15:0]            rsp_sub,
  output logic [15:0]            rsp_data,
  output logic                   listen_only,
  output logic                   port_restart,
  output logic [15:0]            diag_reg
);

  typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_WRITE, ST_RESP, ST_POST}
    state_t;

  state_t            state_q;
  state_t            state_d;
  logic [7:0]        func_q;
  logic              bcast_q;
  logic [15:0]       sub_q;
  logic [15:0]       data_q;
  logic [ADDR_W-1:0] addr_q;
  logic [15:0]       left_q;
  logic [15:0]       words_q;
  logic              addr_ok_q;
  logic              count_ok_q;
  logic              value_ok_q;
  logic              abort_q;
  logic              wpend_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [15:0]       wdata_q;
  logic              listen_q;
  logic              restart_q;
  logic              clear_q;
  logic              enter_listen_q;
  logic              send_q;
  logic [7:0]        rsp_func_q;
  logic              rsp_exc_q;
  logic [7:0]        rsp_code_q;
  logic [15:0]       rsp_sub_q;
  logic [15:0]       rsp_data_q;
  logic [15:0]       diag_q;
  logic [15:0]       diag_d;
  logic              restart_pulse_q;

  diag_cnt_if cif ();

  for (genvar i = 0; i < NUM_CNT; i++)
  begin : g_cnt
    diag_counter #(.IDX(i)) u_cnt (
      .clock (clock),
      .rstn  (rstn),
      .cif   (cif)
    );
  end

  // Function and subfunction decode.
  wire is_read   = (func_q == FC_RD_COILS) || (func_q == FC_RD_INPUTS) ||
                   (func_q == FC_RD_HOLD)  || (func_q == FC_RD_INREG);
  wire is_wr_one = (func_q == FC_WR_COIL)  || (func_q == FC_WR_REG);
  wire is_wr_mul = (func_q == FC_WR_COILS) || (func_q == FC_WR_REGS);
  wire is_rw     = (func_q == FC_RW_REGS);
  wire is_diag   = (func_q == FC_DIAG);
  wire is_write  = is_wr_one || is_wr_mul || is_rw;
  wire func_ok   = is_read || is_write || is_diag;

  wire sub_restart = is_diag && (sub_q == SUB_RESTART);
  wire sub_listen  = is_diag && (sub_q == SUB_LISTEN);
  wire sub_clear   = is_diag && (sub_q == SUB_CLEAR);
  wire sub_cnt     = (sub_q == SUB_BUS_MSG) || (sub_q == SUB_BUS_ERR) ||
                     (sub_q == SUB_EXC_CNT) || (sub_q == SUB_SLV_MSG) ||
                     (sub_q == SUB_NO_RSP)  || (sub_q == SUB_NACK_CNT) ||
                     (sub_q == SUB_OVR_CNT);
  wire sub_ok      = (sub_q == SUB_ECHO) || (sub_q == SUB_RESTART) ||
                     (sub_q == SUB_LISTEN) || (sub_q == SUB_CLEAR) || sub_cnt;

  // Exception priority: function, then address or count, then value,
  // then a failure reported while the action runs.
  wire [7:0] exc_w =
    !func_ok                          ? EXC_FUNCTION :
    (!addr_ok_q || !count_ok_q)       ? EXC_ADDRESS  :
    (!value_ok_q || (is_diag && !sub_ok)) ? EXC_VALUE :
    app_fail                          ? EXC_FAILURE  :
                                        EXC_NONE;

  // Listen-only drops all but a restart, and no answer ever leaves.
  wire dropped   = listen_q && !sub_restart;
  wire send_w    = !listen_q && !bcast_q && !sub_listen;
  wire go_write  = !dropped && (exc_w == EXC_NONE) && is_write;

  wire [15:0] cnt_sel =
    (sub_q == SUB_BUS_MSG)  ? cif.count[CNT_BUS]   :
    (sub_q == SUB_BUS_ERR)  ? cif.count[CNT_CRC]   :
    (sub_q == SUB_EXC_CNT)  ? cif.count[CNT_EXC]   :
    (sub_q == SUB_SLV_MSG)  ? cif.count[CNT_SLV]   :
    (sub_q == SUB_NO_RSP)   ? cif.count[CNT_NORSP] :
    (sub_q == SUB_NACK_CNT) ? cif.count[CNT_NACK]  :
                              cif.count[CNT_OVR];

  // Echo returns the query unchanged; counter reads return the count.
  wire [15:0] diag_val = (is_diag && sub_cnt) ? cnt_sel : data_q;

  wire take_word  = (state_q == ST_WRITE) && word_valid && word_ready;
  wire write_done = (state_q == ST_WRITE) && (left_q == 16'h0000) && !wpend_q;
  wire wr_illegal = wpend_q && reg_wr_bad;
  wire rsp_done   = (state_q == ST_RESP) && rsp_ready;

  assign req_ready     = (state_q == ST_IDLE);
  assign word_ready    = (state_q == ST_WRITE) && !wpend_q &&
                         (left_q != 16'h0000);
  assign rsp_valid     = (state_q == ST_RESP);
  assign two_stop_bits = !parity_en;
  assign reg_wr_req    = wpend_q && !abort_q;
  assign reg_wr_addr   = waddr_q;
  assign reg_wr_data   = wdata_q;
  assign rsp_func      = rsp_func_q;
  assign rsp_exc       = rsp_exc_q;
  assign rsp_code      = rsp_code_q;
  assign rsp_sub       = rsp_sub_q;
  assign rsp_data      = rsp_data_q;
  assign listen_only   = listen_q;
  assign port_restart  = restart_pulse_q;
  assign diag_reg      = diag_q;

  assign cif.inc[CNT_BUS]   = frame_seen;
  assign cif.inc[CNT_CRC]   = frame_crc_err;
  assign cif.inc[CNT_EXC]   = rsp_done && rsp_exc_q;
  assign cif.inc[CNT_SLV]   = (state_q == ST_EXEC);
  assign cif.inc[CNT_NORSP] = (state_q == ST_POST) && !send_q;
  assign cif.inc[CNT_NACK]  = nack_sent;
  assign cif.inc[CNT_OVR]   = frame_overrun;
  assign cif.clear = (state_q == ST_POST) && (restart_q || clear_q);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (req_valid) state_d = ST_EXEC;
      ST_EXEC:
        if (go_write)
          state_d = ST_WRITE;
        else if (send_w && !dropped)
          state_d = ST_RESP;
        else
          state_d = ST_POST;
      ST_WRITE: if (write_done) state_d = send_q ? ST_RESP : ST_POST;
      ST_RESP:  if (rsp_ready) state_d = ST_POST;
      ST_POST:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  // Diagnostic register: hardware events win over a clear in the same cycle.
  always_comb
  begin
    diag_d = cif.clear ? DIAG_RST : diag_q;
    if (frame_crc_err)
      diag_d[DIAG_CRC_BIT] = 1'b1;
    if (frame_overrun)
      diag_d[DIAG_OVR_BIT] = 1'b1;
    if (cif.inc[CNT_EXC])
      diag_d[DIAG_EXC_BIT] = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      diag_q  <= DIAG_RST;
    end
    else
    begin
      state_q <= state_d;
      diag_q  <= diag_d;
    end
  end

  // Request capture.
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      func_q     <= 8'h00;
      bcast_q    <= 1'b0;
      sub_q      <= 16'h0000;
      data_q     <= 16'h0000;
      addr_q     <= '0;
      words_q    <= 16'h0000;
      addr_ok_q  <= 1'b0;
      count_ok_q <= 1'b0;
      value_ok_q <= 1'b0;
    end
    else if (req_valid && req_ready)
    begin
      func_q     <= req_func;
      bcast_q    <= req_bcast;
      sub_q      <= req_sub;
      data_q     <= req_data;
      addr_q     <= req_addr;
      words_q    <= req_words;
      addr_ok_q  <= req_addr_ok;
      count_ok_q <= req_count_ok;
      value_ok_q <= req_value_ok;
    end
  end

  // Write walk. A bad value stops all later writes but earlier ones stay,
  // and remaining words are still drained so the framer is never stuck.
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      left_q  <= 16'h0000;
      abort_q <= 1'b0;
      wpend_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 16'h0000;
    end
    else if (state_q == ST_EXEC)
    begin
      left_q  <= is_wr_one ? 16'h0001 : words_q;
      abort_q <= 1'b0;
      wpend_q <= 1'b0;
      waddr_q <= addr_q;
    end
    else
    begin
      if (take_word)
      begin
        wdata_q <= word_data;
        left_q  <= left_q - 16'h0001;
      end
      wpend_q <= take_word;
      if (wpend_q)
        waddr_q <= waddr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
      if (wr_illegal)
        abort_q <= 1'b1;
    end
  end

  // Answer fields and deferred diagnostic actions.
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      rsp_func_q     <= 8'h00;
      rsp_exc_q      <= 1'b0;
      rsp_code_q     <= EXC_NONE;
      rsp_sub_q      <= 16'h0000;
      rsp_data_q     <= 16'h0000;
      send_q         <= 1'b0;
      restart_q      <= 1'b0;
      clear_q        <= 1'b0;
      enter_listen_q <= 1'b0;
    end
    else if (state_q == ST_EXEC)
    begin
      rsp_func_q     <= func_q;
      rsp_exc_q      <= (exc_w != EXC_NONE);
      rsp_code_q     <= exc_w;
      rsp_sub_q      <= sub_q;
      rsp_data_q     <= diag_val;
      send_q         <= send_w && !dropped;
      restart_q      <= sub_restart && (exc_w == EXC_NONE);
      clear_q        <= sub_clear && !dropped && (exc_w == EXC_NONE);
      enter_listen_q <= sub_listen && !dropped && (exc_w == EXC_NONE);
    end
    else if ((state_q == ST_WRITE) && wr_illegal && !abort_q)
    begin
      rsp_exc_q  <= 1'b1;
      rsp_code_q <= EXC_VALUE;
    end
  end

  // Restart follows the answer, so the answer leaves on the old settings.
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      listen_q        <= 1'b0;
      restart_pulse_q <= 1'b0;
    end
    else
    begin
      restart_pulse_q <= (state_q == ST_POST) && restart_q;
      if ((state_q == ST_POST) && restart_q)
        listen_q <= 1'b0;
      else if ((state_q == ST_POST) && enter_listen_q)
        listen_q <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ==== tb/mb_func_checker.sv ====
// Concurrent checks on the request interpreter ports.
`timescale 1ns/100ps
`default_nettype none
module mb_func_checker
  import mb_func_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        parity_en,
  input wire logic        two_stop_bits,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_func,
  input wire logic        req_bcast,
  input wire logic [15:0] req_sub,
  input wire logic [15:0] req_data,
  input wire logic        req_addr_ok,
  input wire logic        req_count_ok,
  input wire logic        req_value_ok,
  input wire logic        app_fail,
  input wire logic        reg_wr_req,
  input wire logic        reg_wr_bad,
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic [7:0]  rsp_func,
  input wire logic        rsp_exc,
  input wire logic [7:0]  rsp_code,
  input wire logic [15:0] rsp_sub,
  input wire logic [15:0] rsp_data,
  input wire logic        listen_only,
  input wire logic        port_restart
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Broadcasts and listen mode get no answer, so they stay out of take.
  wire take = req_valid && req_ready && !listen_only && !req_bcast;
  wire rd_fc = req_func inside {[FC_RD_COILS:FC_RD_INREG]};
  wire known = rd_fc || req_func inside {FC_WR_COIL, FC_WR_REG, FC_DIAG,
    FC_WR_COILS, FC_WR_REGS, FC_RW_REGS};
  wire sub_ok = req_sub inside {SUB_ECHO, SUB_RESTART, SUB_LISTEN, SUB_CLEAR,
    [SUB_BUS_MSG:SUB_NACK_CNT], SUB_OVR_CNT};
  wire ok3 = req_addr_ok && req_count_ok && req_value_ok;
  wire diag = take && req_func == FC_DIAG && ok3;
  wire rst_req = req_func == FC_DIAG && req_sub == SUB_RESTART && ok3;
  property p_stop;
    two_stop_bits == !parity_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop bits wrong");
  property p_quiet;
    listen_only |-> !rsp_valid && !reg_wr_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("listen sent");
  property p_func;
    take && !known |-> ##2 rsp_valid && rsp_exc && rsp_code == EXC_FUNCTION;
  endproperty
  a_func: assert property (p_func) else $error("no code 1");
  property p_addr;
    take && rd_fc && !(req_addr_ok && req_count_ok) |->
      ##2 rsp_valid && rsp_exc && rsp_code == EXC_ADDRESS;
  endproperty
  a_addr: assert property (p_addr) else $error("no code 2");
  property p_value;
    take && rd_fc && req_addr_ok && req_count_ok && !req_value_ok |->
      ##2 rsp_valid && rsp_exc && rsp_code == EXC_VALUE;
  endproperty
  a_value: assert property (p_value) else $error("no code 3");
  property p_fail;
    take && rd_fc && ok3 ##1 app_fail |-> ##1 rsp_valid && rsp_code == EXC_FAILURE;
  endproperty
  a_fail: assert property (p_fail) else $error("no code 4");
  property p_read;
    take && rd_fc && ok3 ##1 !app_fail |->
      ##1 rsp_valid && !rsp_exc && rsp_func == $past(req_func, 2);
  endproperty
  a_read: assert property (p_read) else $error("read refused");
  property p_echo;
    diag && req_sub == SUB_ECHO ##1 !app_fail |-> ##1 rsp_valid && !rsp_exc
      && rsp_sub == SUB_ECHO && rsp_data == $past(req_data, 2);
  endproperty
  a_echo: assert property (p_echo) else $error("echo differs");
  property p_sub;
    diag && !sub_ok |-> ##2 rsp_valid && rsp_exc && rsp_code == EXC_VALUE;
  endproperty
  a_sub: assert property (p_sub) else $error("bad sub passed");
  property p_wr;
    reg_wr_req && reg_wr_bad |=> !reg_wr_req [*4];
  endproperty
  a_wr: assert property (p_wr) else $error("write after bad");
  property p_rst;
    rsp_valid && rsp_ready && rsp_func == FC_DIAG && rsp_sub == SUB_RESTART
      && !rsp_exc |-> ##2 port_restart;
  endproperty
  a_rst: assert property (p_rst) else $error("no restart");
  property p_lrst;
    listen_only && req_valid && req_ready && rst_req |-> ##[2:6] port_restart;
  endproperty
  a_lrst: assert property (p_lrst) else $error("no quiet restart");
  c_bad: cover property (reg_wr_req && reg_wr_bad);
  c_rst: cover property (port_restart);
  c_lsn: cover property ($rose(listen_only));
endmodule
bind mb_func_handler mb_func_checker i_chk (
  .clock, .rstn, .parity_en, .two_stop_bits, .req_valid, .req_ready,
  .req_func, .req_bcast, .req_sub, .req_data, .req_addr_ok, .req_count_ok,
  .req_value_ok, .app_fail, .reg_wr_req, .reg_wr_bad, .rsp_valid, .rsp_ready,
  .rsp_func, .rsp_exc, .rsp_code, .rsp_sub, .rsp_data, .listen_only,
  .port_restart
);
`default_nettype wire

// ==== tb/mb_reg_map.sv ====
// Register map and write-word source on the far side of the handler.
`timescale 1ns/100ps
`default_nettype none
module mb_reg_map (
  input  wire logic        clock,
  input  wire logic        reg_wr_req,
  input  wire logic [15:0] reg_wr_addr,
  input  wire logic [15:0] reg_wr_data,
  output logic             reg_wr_bad,
  output var logic         word_valid,
  input  wire logic        word_ready,
  output var logic [15:0]  word_data
);
  logic [15:0] mem [256];
  logic [15:0] words [$];
  logic        took = 1'b0;
  // A value whose top byte is all ones is out of range in this map.
  assign reg_wr_bad = reg_wr_req && reg_wr_data[15:8] == 8'hff;
  initial
  begin
    foreach (mem[i])
      mem[i] = 16'h0000;
    word_valid = 1'b0;
    word_data = 16'h0000;
  end
  // A flagged word is never committed, so only the handler's stop shows.
  always @(posedge clock)
  begin
    took <= word_valid && word_ready;
    if (reg_wr_req && !reg_wr_bad)
      mem[reg_wr_addr[7:0]] <= reg_wr_data;
  end
  // Idle data lines toggle so a stale word can never pass for a new one.
  always @(negedge clock)
  begin
    if (took)
      void'(words.pop_front());
    word_valid = words.size() != 0;
    word_data = word_valid ? words[0] : ~word_data;
  end
endmodule
`default_nettype wire

// ==== tb/mb_func_handler_tb_top.sv ====
// Self-checking bench for the request interpreter and its counters.
`timescale 1ns/100ps
`default_nettype none
module mb_func_handler_tb_top
  import mb_func_pkg::*;
;
  logic        clock = '0, rstn = '0, frame_seen = '0, frame_crc_err = '0;
  logic        frame_overrun = '0, nack_sent = '0, parity_en = '0;
  logic        req_valid = '0, req_bcast = '0, req_addr_ok = '0;
  logic        req_count_ok = '0, req_value_ok = '0, app_fail = '0;
  logic        rsp_ready = '0;
  logic [7:0]  req_func = '0;
  logic [15:0] req_sub = '0, req_data = '0, req_addr = '0, req_words = '0;
  wire         two_stop_bits, req_ready, word_valid, word_ready, reg_wr_req;
  wire         reg_wr_bad, rsp_valid, rsp_exc, listen_only, port_restart;
  wire  [7:0]  rsp_func, rsp_code;
  wire  [15:0] word_data, reg_wr_addr, reg_wr_data, rsp_sub, rsp_data;
  wire  [15:0] diag_reg;
  int          miscompares = 0, comparisons = 0, n, j, k;
  int          cnt [6];
  logic [7:0]  f, r_code, r_func;
  logic [2:0]  ok;
  logic        fl, r_exc;
  logic [15:0] d, r_data, r_sub;
  logic [15:0] subs [6];
  logic [7:0]  wfc [5] = '{FC_WR_COIL, FC_WR_REG, FC_WR_COILS, FC_WR_REGS,
                           FC_RW_REGS};
  mb_func_handler i_dut (
    .clock, .rstn, .frame_seen, .frame_crc_err, .frame_overrun, .nack_sent,
    .parity_en, .two_stop_bits, .req_valid, .req_ready, .req_func, .req_bcast,
    .req_sub, .req_data, .req_addr, .req_words, .req_addr_ok, .req_count_ok,
    .req_value_ok, .app_fail, .word_valid, .word_ready, .word_data,
    .reg_wr_req, .reg_wr_addr, .reg_wr_data, .reg_wr_bad, .rsp_valid,
    .rsp_ready, .rsp_func, .rsp_exc, .rsp_code, .rsp_sub, .rsp_data,
    .listen_only, .port_restart, .diag_reg
  );
  mb_reg_map i_map (
    .clock, .reg_wr_req, .reg_wr_addr, .reg_wr_data, .reg_wr_bad,
    .word_valid, .word_ready, .word_data
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic pulse(input int num, input logic [3:0] m);
    repeat (num)
    begin
      @(negedge clock);
      {frame_seen, frame_crc_err, frame_overrun, nack_sent} = m;
    end
    @(negedge clock);
    {frame_seen, frame_crc_err, frame_overrun, nack_sent} = 4'h0;
  endtask
  // The answer is held back a random few cycles to test that it stands.
  task automatic req(input logic [7:0] fc, input logic [15:0] sub, dat,
                     input logic [2:0] oks, input logic bc, want);
    int i;
    logic got;
    @(negedge clock);
    {req_func, req_sub, req_data} = {fc, sub, dat};
    {req_addr_ok, req_count_ok, req_value_ok, req_bcast} = {oks, bc};
    req_valid = 1'b1;
    for (i = 0; i < 50 && req_ready !== 1'b1; i++)
      @(negedge clock);
    if (i == 50)
    begin
      miscompares++;
      finish_test();
    end
    @(negedge clock);
    req_valid = 1'b0;
    got = 1'b0;
    // A line master waits far longer; this block answers within cycles.
    for (i = 0; i < 40 && !got; i++)
    begin
      @(negedge clock);
      if (rsp_valid === 1'b1)
      begin
        repeat ($urandom_range(0, 2)) @(negedge clock);
        rsp_ready = 1'b1;
        {r_func, r_exc, r_code} = {rsp_func, rsp_exc, rsp_code};
        {r_sub, r_data} = {rsp_sub, rsp_data};
        @(negedge clock);
        rsp_ready = 1'b0;
        got = 1'b1;
      end
    end
    app_fail = 1'b0;
    check(16'(got), 16'(want));
  endtask
  function automatic logic [7:0] exp_code(input logic [7:0] fc,
                                          input logic [2:0] oks, input logic x);
    if (!(fc inside {[8'h01:8'h04]}))
      return EXC_FUNCTION;
    if (!(oks[2] && oks[1]))
      return EXC_ADDRESS;
    if (!oks[0])
      return EXC_VALUE;
    return x ? EXC_FAILURE : EXC_NONE;
  endfunction
  initial
  begin
    forever #20 clock = ~clock;
  end
  initial
  begin
    void'($urandom(32'h29be_68fc));
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    check(16'(two_stop_bits), 16'h0001);
    parity_en = 1'b1;
    #1 check(16'(two_stop_bits), 16'h0000);
    for (n = 0; n < 24; n++)
    begin
      f = n < 2 ? 8'(n * 9) : 8'($urandom_range(1, 4));
      if (n % 4 == 3)
        f = 8'($urandom_range(24, 255));
      ok = $urandom_range(0, 1) ? 3'b111 : 3'($urandom);
      req_addr = 16'($urandom);
      fl = $urandom_range(0, 3) == 0;
      app_fail = fl;
      req(f, 16'h0000, 16'h0000, ok, 1'b0, 1'b1);
      check(16'(r_code), 16'(exp_code(f, ok, fl)));
      check(16'(r_exc), 16'(exp_code(f, ok, fl) != 0));
      check(16'(r_func), 16'(f));
    end
    for (n = 0; n < 5; n++)
    begin
      k = n < 2 ? 1 : 2;
      for (j = 0; j < k; j++)
        i_map.words.push_back(16'(16'h1000 * (n + 1) + j));
      req_addr = 16'(32 + n * 4);
      req_words = 16'(k);
      req(wfc[n], 16'h0000, 16'h0000, 3'b111, 1'b0, 1'b1);
      check(16'(r_code), 16'h0000);
      for (j = 0; j < k; j++)
        check(i_map.mem[32 + n * 4 + j], 16'(16'h1000 * (n + 1) + j));
    end
    req_addr = 16'h0040;
    req_words = 16'h0004;
    i_map.words = '{16'h1111, 16'h2222, 16'hff00, 16'h4444};
    req(FC_WR_REGS, 16'h0000, 16'h0000, 3'b111, 1'b0, 1'b1);
    check(16'(r_code), 16'(EXC_VALUE));
    check(i_map.mem[65], 16'h2222);
    check(i_map.mem[66], 16'h0000);
    check(i_map.mem[67], 16'h0000);
    d = 16'($urandom);
    req(FC_DIAG, SUB_ECHO, d, 3'b111, 1'b0, 1'b1);
    check(r_data, d);
    check(r_sub, SUB_ECHO);
    subs = '{16'h0002, 16'h0003, 16'h0011, 16'h0013, 16'h00ff, 16'hffff};
    foreach (subs[i])
    begin
      req(FC_DIAG, subs[i], 16'h0000, 3'b111, 1'b0, 1'b1);
      check(16'(r_code), 16'(EXC_VALUE));
    end
    req(FC_DIAG, SUB_CLEAR, 16'h0000, 3'b111, 1'b0, 1'b1);
    for (j = 0; j < 4; j++)
    begin
      cnt[j] = $urandom_range(1, 5);
      pulse(cnt[j], 4'(8 >> j));
    end
    cnt[4] = 2;
    cnt[5] = 2;
    repeat (2)
    begin
      req(8'h30, 16'h0000, 16'h0000, 3'b111, 1'b0, 1'b1);
      req(FC_RD_HOLD, 16'h0000, 16'h0000, 3'b111, 1'b1, 1'b0);
    end
    check(diag_reg, 16'h0007);
    subs = '{SUB_BUS_MSG, SUB_BUS_ERR, SUB_OVR_CNT, SUB_NACK_CNT, SUB_EXC_CNT,
             SUB_NO_RSP};
    for (j = 0; j < 6; j++)
    begin
      req(FC_DIAG, subs[j], 16'h0000, 3'b111, 1'b0, 1'b1);
      check(r_data, 16'(cnt[j]));
    end
    // Four requests and six readbacks were processed since the clear.
    req(FC_DIAG, SUB_SLV_MSG, 16'h0000, 3'b111, 1'b0, 1'b1);
    check(r_data, 16'h000a);
    req(FC_DIAG, SUB_CLEAR, 16'h0000, 3'b111, 1'b0, 1'b1);
    repeat (2) @(negedge clock);
    check(diag_reg, 16'h0000);
    req(FC_DIAG, SUB_BUS_ERR, 16'h0000, 3'b111, 1'b0, 1'b1);
    check(r_data, 16'h0000);
    req(FC_DIAG, SUB_LISTEN, 16'h0000, 3'b111, 1'b0, 1'b0);
    check(16'(listen_only), 16'h0001);
    pulse(3, 4'h8);
    req(FC_RD_HOLD, 16'h0000, 16'h0000, 3'b111, 1'b0, 1'b0);
    req(FC_DIAG, SUB_RESTART, 16'h0000, 3'b111, 1'b0, 1'b0);
    check(16'(listen_only), 16'h0000);
    req(FC_DIAG, SUB_BUS_MSG, 16'h0000, 3'b111, 1'b0, 1'b1);
    check(r_data, 16'h0000);
    d = 16'($urandom);
    req(FC_DIAG, SUB_RESTART, d, 3'b111, 1'b0, 1'b1);
    check(r_data, d);
    pulse(65537, 4'h8);
    req(FC_DIAG, SUB_BUS_MSG, 16'h0000, 3'b111, 1'b0, 1'b1);
    check(r_data, 16'h0001);
    finish_test();
  end
endmodule
`default_nettype wire
